/* core/dcst_pkg.sv */
// Constants, types and register map of the DC servo trigger control block.
// Assumes a 100 MHz mclk and the plain address/strobe register port of the top module.
//
// Operation
// - Writing one to bits 15..12 starts one correction on that channel.
// - A running single correction reads back as one in its single bit.
// - Writing one to bits 11..8 starts a series of corrections on that channel.
// - Running series or preset correction reads one in series and preset bits.
// - Bits 7..4 start power-up correction; the bit reads one while it runs.
// - Bits 3..0 start preset correction; bit 0 phone left, bit 3 line right.
// - Update interval is 0.256 s times two to the code; code zero is off.
// - Line pair code in bits 11..8, phone pair in 3..0, both reset 1010.
// - A series performs count plus one updates; both counts reset to 0x2a.
// - Each channel has its own servo enable bit, index 0 phone left.
// - Preset mode applies an 8-bit two's complement offset; readback shows current offset.
// - Finishing preset or power-up correction sets that channel's done flag.
package dcst_pkg;
	localparam logic [7:0] A_ENA  = 8'h43;
	localparam logic [7:0] A_TRIG = 8'h44;
	localparam logic [7:0] A_IVL  = 8'h45;
	localparam logic [7:0] A_LCNT = 8'h47;
	localparam logic [7:0] A_PCNT = 8'h48;
	localparam logic [7:0] A_OFF3 = 8'h49;
	localparam logic [7:0] A_OFF0 = 8'h4c;
	localparam logic [7:0] A_DONE = 8'h4d;
	localparam logic [7:0] A_IST  = 8'h4e;
	localparam logic [7:0] A_IMSK = 8'h4f;

	localparam int F_SINGLE  = 12;
	localparam int F_SERIES  = 8;
	localparam int F_STARTUP = 4;
	localparam int F_DACWR   = 0;
	localparam int F_IVL_LN  = 8;
	localparam int F_IVL_PH  = 0;
	localparam int F_DONE    = 8;

	localparam logic [3:0]  IVL_RST   = 4'ha;
	localparam logic [6:0]  CNT_RST   = 7'h2a;
	localparam logic [15:0] IVL_FIXED = 16'h00a0;

	localparam int CLK_NS   = 10;
	localparam int BASE_MS  = 256;
	localparam int BASE_CYC = BASE_MS * 1000000 / CLK_NS;
	localparam int STEP_NS  = 1000;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		M_NONE    = 4'h0,
		M_SINGLE  = 4'h1,
		M_SERIES  = 4'h2,
		M_STARTUP = 4'h4,
		M_DACWR   = 4'h8
	} dcst_mode_t;

	typedef struct packed {
		logic single;
		logic series;
		logic startup;
		logic dacwr;
	} dcst_busy_t;
endpackage

/* core/dcst_timer.sv */
// Periodic update timer for one output pair.
// Assumes the interval code comes from a register on the same clock.
`timescale 1ns/1ns
module dcst_timer #(
	parameter int BASE_CYC = dcst_pkg::BASE_CYC
) (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic [3:0] code,
	output logic            tick
);
	logic [31:0] pre;
	logic [31:0] next_pre;
	logic [14:0] cnt;
	logic [14:0] next_cnt;
	logic [3:0]  code_q;
	logic [14:0] last;

	// A new code restarts the interval so the first tick is never early.
	always_comb begin
		last     = 15'((32'h1 << code) - 32'h1);
		next_pre = pre;
		next_cnt = cnt;
		tick     = 1'b0;
		if (code == 4'h0 || code != code_q) begin
			next_pre = 32'h0;
			next_cnt = 15'h0;
		end else if (pre != 32'(BASE_CYC - 1)) begin
			next_pre = pre + 32'h1;
		end else begin
			next_pre = 32'h0;
			if (cnt == last) begin
				next_cnt = 15'h0;
				tick     = ce;
			end else begin
				next_cnt = cnt + 15'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pre    <= 32'h0;
			cnt    <= 15'h0;
			code_q <= 4'h0;
		end else if (ce) begin
			pre    <= next_pre;
			cnt    <= next_cnt;
			code_q <= code;
		end
	end

	tick_off_a: assert property (@(posedge mclk) disable iff (srst) code == 4'h0 |-> !tick)
		else $error("timer ticked while periodic updates are off");
endmodule // dcst_timer

/* core/dcst_chan.sv */
// Correction sequencer for one output channel.
// Assumes requests are one-cycle pulses and at most one mode is requested at a time.
`timescale 1ns/1ns
module dcst_chan #(
	parameter int STEP_CYC = dcst_pkg::STEP_CYC
) (
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                ce,
	input  wire logic                enable,
	input  dcst_pkg::dcst_mode_t     req,
	input  wire logic [6:0]          len,
	input  wire logic                tick,
	output logic                     step,
	output logic                     done,
	output dcst_pkg::dcst_mode_t     mode,
	output dcst_pkg::dcst_busy_t     busy
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_RUN  = 2'b10
	} dcst_state_t;

	dcst_state_t          state;
	dcst_state_t          next_state;
	dcst_pkg::dcst_mode_t next_mode;
	logic [6:0]           left;
	logic [6:0]           next_left;
	logic [15:0]          tmr;
	logic [15:0]          next_tmr;

	always_comb begin
		next_state = state;
		next_mode  = mode;
		next_left  = left;
		next_tmr   = tmr;
		step       = 1'b0;
		done       = 1'b0;
		unique case (state)
			S_IDLE: begin
				if (enable && req != dcst_pkg::M_NONE) begin
					next_mode  = req;
					// A series runs its count plus one updates.
					next_left  = (req == dcst_pkg::M_SERIES) ? len : 7'h0;
					next_tmr   = 16'(STEP_CYC - 1);
					next_state = S_RUN;
					step       = ce;
				end else if (enable && tick) begin
					next_mode  = dcst_pkg::M_SINGLE;
					next_left  = 7'h0;
					next_tmr   = 16'(STEP_CYC - 1);
					next_state = S_RUN;
					step       = ce;
				end
			end
			S_RUN: begin
				if (!enable) begin
					next_state = S_IDLE;
					next_mode  = dcst_pkg::M_NONE;
				end else if (tmr != 16'h0) begin
					next_tmr = tmr - 16'h1;
				end else if (left != 7'h0) begin
					next_left = left - 7'h1;
					next_tmr  = 16'(STEP_CYC - 1);
					step      = ce;
				end else begin
					// Finishing clears the mode, which self-clears the trigger bit.
					next_state = S_IDLE;
					next_mode  = dcst_pkg::M_NONE;
					done       = ce;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= S_IDLE;
			mode  <= dcst_pkg::M_NONE;
			left  <= 7'h0;
			tmr   <= 16'h0;
		end else if (ce) begin
			state <= next_state;
			mode  <= next_mode;
			left  <= next_left;
			tmr   <= next_tmr;
		end
	end

	assign busy.single  = mode == dcst_pkg::M_SINGLE;
	assign busy.series  = mode == dcst_pkg::M_SERIES || mode == dcst_pkg::M_DACWR;
	assign busy.startup = mode == dcst_pkg::M_STARTUP;
	assign busy.dacwr   = busy.series;

	series_len_a: assert property (@(posedge mclk) disable iff (srst)
		state == S_IDLE && enable && ce && req == dcst_pkg::M_SERIES |=> left == $past(len))
		else $error("series did not load its update count");
	ena_off_a: assert property (@(posedge mclk) disable iff (srst)
		!enable && ce |=> state == S_IDLE)
		else $error("disabled channel kept running");
endmodule // dcst_chan

/* core/dcst_ctrl.sv */
// Top of the DC servo trigger control: register port, four channel sequencers, two pair timers.
// Assumes a single-cycle write/read strobe master on mclk and an analogue servo that
// performs one update per servo_step pulse.
`timescale 1ns/1ns
module dcst_ctrl #(
	parameter int BASE_CYC = dcst_pkg::BASE_CYC,
	parameter int STEP_CYC = dcst_pkg::STEP_CYC
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic      [3:0]  servo_step,
	output logic      [3:0]  servo_active,
	output logic      [31:0] cur_offset,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Register state.

	logic [3:0]  ena;
	logic [3:0]  next_ena;
	logic [3:0]  ivl_line;
	logic [3:0]  next_ivl_line;
	logic [3:0]  ivl_phone;
	logic [3:0]  next_ivl_phone;
	logic [6:0]  cnt_line;
	logic [6:0]  next_cnt_line;
	logic [6:0]  cnt_phone;
	logic [6:0]  next_cnt_phone;
	logic [7:0]  preset     [4];
	logic [7:0]  next_preset[4];
	logic [7:0]  cur_off     [4];
	logic [7:0]  next_cur_off[4];
	logic [3:0]  done_flags;
	logic [3:0]  next_done_flags;
	logic [3:0]  ist;
	logic [3:0]  next_ist;
	logic [3:0]  imsk;
	logic [3:0]  next_imsk;
	logic [15:0] next_rdata;

	dcst_pkg::dcst_mode_t req [4];
	dcst_pkg::dcst_mode_t mode[4];
	dcst_pkg::dcst_busy_t busy[4];
	logic [3:0]           done;
	logic [3:0]           tick_pair;
	logic [15:0]          trig_rb;
	logic [15:0]          ivl_rb;
	logic                 wr_trig;

	assign wr_trig = wr && addr == dcst_pkg::A_TRIG;

	////////////////////////////////////////////////////////////////////////////////
	// Trigger decode. Only ones start anything; a busy channel ignores new triggers.

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			req[i] = dcst_pkg::M_NONE;
			if (wr_trig && mode[i] == dcst_pkg::M_NONE) begin
				if (wdata[dcst_pkg::F_STARTUP + i]) begin
					req[i] = dcst_pkg::M_STARTUP;
				end else if (wdata[dcst_pkg::F_DACWR + i]) begin
					req[i] = dcst_pkg::M_DACWR;
				end else if (wdata[dcst_pkg::F_SERIES + i]) begin
					req[i] = dcst_pkg::M_SERIES;
				end else if (wdata[dcst_pkg::F_SINGLE + i]) begin
					req[i] = dcst_pkg::M_SINGLE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channels and timers. Channels 2 and 3 are the line pair, 0 and 1 the phone pair.

	dcst_timer #(
		.BASE_CYC(BASE_CYC)
	) u_tmr_phone (
		.mclk(mclk),
		.srst(srst),
		.ce  (ce),
		.code(ivl_phone),
		.tick(tick_pair[0])
	);

	dcst_timer #(
		.BASE_CYC(BASE_CYC)
	) u_tmr_line (
		.mclk(mclk),
		.srst(srst),
		.ce  (ce),
		.code(ivl_line),
		.tick(tick_pair[1])
	);

	for (genvar g = 0; g < 4; g++) begin : g_chan
		dcst_chan #(
			.STEP_CYC(STEP_CYC)
		) u_chan (
			.mclk  (mclk),
			.srst  (srst),
			.ce    (ce),
			.enable(ena[g]),
			.req   (req[g]),
			.len   ((g >= 2) ? cnt_line : cnt_phone),
			.tick  (tick_pair[g / 2]),
			.step  (servo_step[g]),
			.done  (done[g]),
			.mode  (mode[g]),
			.busy  (busy[g])
		);
		assign servo_active[g]           = mode[g] != dcst_pkg::M_NONE;
		assign cur_offset[g*8 +: 8]      = cur_off[g];
		assign trig_rb[dcst_pkg::F_SINGLE + g]  = busy[g].single;
		assign trig_rb[dcst_pkg::F_SERIES + g]  = busy[g].series;
		assign trig_rb[dcst_pkg::F_STARTUP + g] = busy[g].startup;
		assign trig_rb[dcst_pkg::F_DACWR + g]   = busy[g].dacwr;
	end

	assign ivl_rb = dcst_pkg::IVL_FIXED
		| {4'h0, ivl_line, 8'h00} | {12'h000, ivl_phone};

	////////////////////////////////////////////////////////////////////////////////
	// Register updates and readback.

	always_comb begin
		next_ena        = ena;
		next_ivl_line   = ivl_line;
		next_ivl_phone  = ivl_phone;
		next_cnt_line   = cnt_line;
		next_cnt_phone  = cnt_phone;
		next_done_flags = done_flags;
		next_ist        = ist;
		next_imsk       = imsk;
		next_rdata      = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			next_preset[i]  = preset[i];
			next_cur_off[i] = cur_off[i];
		end
		if (wr) begin
			unique case (addr)
				dcst_pkg::A_ENA:  next_ena = wdata[3:0];
				dcst_pkg::A_IVL: begin
					next_ivl_line  = wdata[dcst_pkg::F_IVL_LN +: 4];
					next_ivl_phone = wdata[dcst_pkg::F_IVL_PH +: 4];
				end
				dcst_pkg::A_LCNT: next_cnt_line = wdata[6:0];
				dcst_pkg::A_PCNT: next_cnt_phone = wdata[6:0];
				dcst_pkg::A_IST:  next_ist = ist & ~wdata[3:0];
				dcst_pkg::A_IMSK: next_imsk = wdata[3:0];
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (addr == dcst_pkg::A_OFF0 - 8'(i)) begin
							next_preset[i] = wdata[7:0];
						end
					end
				end
			endcase
		end
		for (int i = 0; i < 4; i++) begin
			// A new power-up or preset run reads as incomplete until it finishes.
			if (ena[i] && (req[i] == dcst_pkg::M_STARTUP || req[i] == dcst_pkg::M_DACWR)) begin
				next_done_flags[i] = 1'b0;
			end
			if (done[i] && (mode[i] == dcst_pkg::M_STARTUP || mode[i] == dcst_pkg::M_DACWR)) begin
				next_done_flags[i] = 1'b1;
			end
			if (done[i] && mode[i] == dcst_pkg::M_DACWR) begin
				next_cur_off[i] = preset[i];
			end
			// Set wins over a write-one clear in the same cycle.
			if (done[i]) begin
				next_ist[i] = 1'b1;
			end
		end
		if (rd) begin
			unique case (addr)
				dcst_pkg::A_ENA:  next_rdata = {12'h000, ena};
				dcst_pkg::A_TRIG: next_rdata = trig_rb;
				dcst_pkg::A_IVL:  next_rdata = ivl_rb;
				dcst_pkg::A_LCNT: next_rdata = {9'h000, cnt_line};
				dcst_pkg::A_PCNT: next_rdata = {9'h000, cnt_phone};
				dcst_pkg::A_DONE: next_rdata = {4'h0, done_flags, 8'h00};
				dcst_pkg::A_IST:  next_rdata = {12'h000, ist};
				dcst_pkg::A_IMSK: next_rdata = {12'h000, imsk};
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (addr == dcst_pkg::A_OFF0 - 8'(i)) begin
							next_rdata = {8'h00, cur_off[i]};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ena        <= 4'h0;
			ivl_line   <= dcst_pkg::IVL_RST;
			ivl_phone  <= dcst_pkg::IVL_RST;
			cnt_line   <= dcst_pkg::CNT_RST;
			cnt_phone  <= dcst_pkg::CNT_RST;
			done_flags <= 4'h0;
			ist        <= 4'h0;
			imsk       <= 4'h0;
			rdata      <= 16'h0000;
			for (int i = 0; i < 4; i++) begin
				preset[i]  <= 8'h00;
				cur_off[i] <= 8'h00;
			end
		end else if (ce) begin
			ena        <= next_ena;
			ivl_line   <= next_ivl_line;
			ivl_phone  <= next_ivl_phone;
			cnt_line   <= next_cnt_line;
			cnt_phone  <= next_cnt_phone;
			done_flags <= next_done_flags;
			ist        <= next_ist;
			imsk       <= next_imsk;
			rdata      <= next_rdata;
			for (int i = 0; i < 4; i++) begin
				preset[i]  <= next_preset[i];
				cur_off[i] <= next_cur_off[i];
			end
		end
	end

	assign irq = |(ist & imsk);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	trig_single_a: assert property (@(posedge mclk) disable iff (srst)
		ce && ena[3] && req[3] == dcst_pkg::M_SINGLE |=> trig_rb[dcst_pkg::F_SINGLE + 3] && servo_active[3])
		else $error("single trigger did not start the correction");
	single_rb_a: assert property (@(posedge mclk) disable iff (srst)
		ce && rd && addr == dcst_pkg::A_TRIG && mode[0] == dcst_pkg::M_SINGLE |=> rdata[dcst_pkg::F_SINGLE])
		else $error("running single correction not shown");
	series_rb_a: assert property (@(posedge mclk) disable iff (srst)
		ce && rd && addr == dcst_pkg::A_TRIG && (mode[0] == dcst_pkg::M_SERIES || mode[0] == dcst_pkg::M_DACWR)
		|=> rdata[dcst_pkg::F_SERIES] && rdata[dcst_pkg::F_DACWR])
		else $error("series or preset run not shown in both bits");
	startup_a: assert property (@(posedge mclk) disable iff (srst)
		ce && ena[1] && req[1] == dcst_pkg::M_STARTUP
		|=> trig_rb[dcst_pkg::F_STARTUP + 1] until (done[1] || !ena[1]))
		else $error("power-up bit not held while running");
	dacwr_off_a: assert property (@(posedge mclk) disable iff (srst)
		ce && done[2] && mode[2] == dcst_pkg::M_DACWR |=> cur_off[2] == $past(preset[2]))
		else $error("preset offset not applied on finish");
	done_flag_a: assert property (@(posedge mclk) disable iff (srst)
		ce && done[1] && mode[1] == dcst_pkg::M_STARTUP |=> done_flags[1])
		else $error("done flag not set after power-up run");
	ivl_rst_a: assert property (@(posedge mclk)
		$past(srst) && !srst && $past(ce, 1) |-> ivl_rb == 16'h0aaa)
		else $error("interval register reset value wrong");
	no_start_a: assert property (@(posedge mclk) disable iff (srst)
		ce && wr_trig && wdata[dcst_pkg::F_SINGLE +: 4] == 4'h0 && wdata[11:0] == 12'h000
		&& mode[1] == dcst_pkg::M_NONE |-> req[1] == dcst_pkg::M_NONE)
		else $error("writing zeros started a correction");
	ena_start_a: assert property (@(posedge mclk) disable iff (srst)
		ce && !ena[2] && req[2] != dcst_pkg::M_NONE |=> !servo_active[2])
		else $error("disabled channel accepted a trigger");

	series_c: cover property (@(posedge mclk) disable iff (srst) req[0] == dcst_pkg::M_SERIES ##[1:300] done[0]);
	dacwr_c: cover property (@(posedge mclk) disable iff (srst) done[2] && mode[2] == dcst_pkg::M_DACWR);
	irq_c: cover property (@(posedge mclk) disable iff (srst) $rose(irq));
endmodule // dcst_ctrl

/* dv/dcst_ctrl_tb.sv */
// Self-checking bench for the DC servo trigger control top: register port, triggers, counts, interrupts.
// Assumes the top as handed over; the bench drives every port itself, with shortened timer and step counts.
`timescale 1ns/1ns
module dcst_ctrl_tb;
	localparam int BASE = 4;
	localparam int STEP = 4;
	logic        mclk     = 1'b0;
	logic        srst     = 1'b1;
	logic        ce       = 1'b1;
	logic [7:0]  addr     = 8'h00;
	logic [15:0] wdata    = 16'h0000;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic [15:0] rdata;
	logic [3:0]  servo_step;
	logic [3:0]  servo_active;
	logic [31:0] cur_offset;
	logic        irq;
	logic        rd_q     = 1'b0;
	logic [31:0] exp_q [$];
	logic [31:0] e_now;
	logic [7:0]  ofs;
	logic [6:0]  len;
	int          steps [4] = '{0, 0, 0, 0};
	int          fails    = 0;
	int          checked  = 0;
	int          cyc      = 0;
	int          seed     = 89;
	int          s;
	int          s2;

	always #5 mclk = ~mclk;

	dcst_ctrl #(.BASE_CYC(BASE), .STEP_CYC(STEP)) dcst_ctrl_inst (
		.mclk         (mclk),
		.srst         (srst),
		.ce           (ce),
		.addr         (addr),
		.wdata        (wdata),
		.wr           (wr),
		.rd           (rd),
		.rdata        (rdata),
		.servo_step   (servo_step),
		.servo_active (servo_active),
		.cur_offset   (cur_offset),
		.irq          (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	// The expectation is queued here and compared by the monitor when the data stand.
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back({m, e});
		@(posedge mclk);
		rd <= 1'b0;
		#1;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (servo_active !== 4'h0 && n < 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 300) begin
			fails++;
			$display("[FAIL] %0t correction never finished", $time);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		if (rd_q) begin
			e_now = exp_q.pop_front();
			chk(rdata & e_now[31:16], e_now[15:0]);
		end
		rd_q <= rd;
	end

	// Step pulses are combinational, so they are counted at the edge that ends their cycle.
	always @(posedge mclk) begin
		for (int i = 0; i < 4; i++) begin
			if (servo_step[i] === 1'b1) begin
				steps[i] <= steps[i] + 1;
			end
		end
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			$display("[FAIL] %0t run timed out", $time);
			wrap_up;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rd_reg(dcst_pkg::A_IVL, 16'hffff, 16'h0aaa);
		rd_reg(dcst_pkg::A_LCNT, 16'hffff, 16'h002a);
		rd_reg(dcst_pkg::A_PCNT, 16'hffff, 16'h002a);
		rd_reg(dcst_pkg::A_ENA, 16'hffff, 16'h0000);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0000);
		rd_reg(dcst_pkg::A_DONE, 16'hffff, 16'h0000);
		rd_reg(8'h46, 16'hffff, 16'h0000);
		// Periodic updates are switched off so that they cannot add steps to the counted runs.
		wr_reg(dcst_pkg::A_IVL, 16'h0000);
		rd_reg(dcst_pkg::A_IVL, 16'hffff, 16'h00a0);
		$display("test reset done");
		wr_reg(dcst_pkg::A_ENA, 16'h000a);
		s  = steps[0];
		s2 = steps[2];
		wr_reg(dcst_pkg::A_TRIG, 16'h5000);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0000);
		chk(16'(steps[0] - s), 16'h0000);
		chk(16'(steps[2] - s2), 16'h0000);
		wr_reg(dcst_pkg::A_ENA, 16'h000f);
		$display("test disabled done");
		s  = steps[0];
		s2 = steps[3];
		wr_reg(dcst_pkg::A_TRIG, 16'h9000);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h9000);
		wait_idle;
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0000);
		chk(16'(steps[0] - s), 16'h0001);
		chk(16'(steps[3] - s2), 16'h0001);
		$display("test single done");
		// A low clock enable must hold a running correction where it stands.
		s = steps[0];
		wr_reg(dcst_pkg::A_TRIG, 16'h1000);
		@(posedge mclk);
		ce <= 1'b0;
		repeat (20) @(posedge mclk);
		#1;
		chk({15'h0000, servo_active[0]}, 16'h0001);
		@(posedge mclk);
		ce <= 1'b1;
		wait_idle;
		chk(16'(steps[0] - s), 16'h0001);
		$display("test freeze done");
		len = 7'($random(seed)) & 7'h07;
		wr_reg(dcst_pkg::A_LCNT, {9'h000, len});
		rd_reg(dcst_pkg::A_LCNT, 16'hffff, {9'h000, len});
		wr_reg(dcst_pkg::A_PCNT, 16'h0002);
		s  = steps[3];
		s2 = steps[0];
		wr_reg(dcst_pkg::A_TRIG, 16'h0900);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0909);
		wait_idle;
		chk(16'(steps[3] - s), 16'(len) + 16'h0001);
		chk(16'(steps[0] - s2), 16'h0003);
		$display("test series done");
		wr_reg(dcst_pkg::A_TRIG, 16'h0020);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0020);
		wait_idle;
		rd_reg(dcst_pkg::A_DONE, 16'h0f00, 16'h0200);
		$display("test power-up done");
		ofs = 8'($random(seed));
		wr_reg(8'h4a, {8'h00, ofs});
		wr_reg(dcst_pkg::A_TRIG, 16'h0004);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0404);
		wait_idle;
		chk({8'h00, cur_offset[23:16]}, {8'h00, ofs});
		rd_reg(8'h4a, 16'h00ff, {8'h00, ofs});
		rd_reg(dcst_pkg::A_DONE, 16'h0f00, 16'h0600);
		wr_reg(dcst_pkg::A_TRIG, 16'h0000);
		rd_reg(dcst_pkg::A_TRIG, 16'hffff, 16'h0000);
		$display("test preset done");
		rd_reg(dcst_pkg::A_IST, 16'hffff, 16'h000f);
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(dcst_pkg::A_IMSK, 16'h0004);
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(dcst_pkg::A_IST, 16'h0004);
		chk({15'h0000, irq}, 16'h0000);
		rd_reg(dcst_pkg::A_IST, 16'hffff, 16'h000b);
		$display("test interrupt done");
		s  = steps[0];
		s2 = steps[2];
		wr_reg(dcst_pkg::A_IVL, 16'h0001);
		repeat (60) @(posedge mclk);
		#1;
		chk({15'h0000, steps[0] != s}, 16'h0001);
		chk(16'(steps[2] - s2), 16'h0000);
		wr_reg(dcst_pkg::A_IVL, 16'h0000);
		wait_idle;
		$display("test periodic done");
		repeat (2) @(posedge mclk);
		wrap_up;
	end
endmodule // dcst_ctrl_tb
